// *** core/nsf_feat_dec.sv ***
// Purpose: Decodes a feature-setting command into an apply strobe or an error
// Assumes: One command at a time, spaced at least two cycles apart
// Notes: Results are registered and appear one cycle after the command

`timescale 1ns/1ns

module nsf_feat_dec
   import nsf_pkg::*;
#(
   parameter bit CACHE_SUPPORTED = 1'b1
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cmd_valid_i,
   input wire logic [31:0] cdw10_i,
   input wire logic [31:0] cdw11_i,
   output logic done_o,
   output logic [7:0] status_o,
   output logic apply_o,
   output logic [7:0] sel_o,
   output logic [31:0] val_o
);
   logic done_reg, done_next, apply_reg, apply_next, ok;
   logic [7:0] status_reg, status_next, sel_reg, sel_next;
   logic [31:0] val_reg, val_next;

   always_comb begin
      // only the low selector byte is looked at
      sel_next = cdw10_i[7:0];
      ok = (sel_next >= NSF_FEAT_FIRST) && (sel_next <= NSF_FEAT_LAST) &&
           (CACHE_SUPPORTED || (sel_next != NSF_FEAT_CACHE));
      done_next = cmd_valid_i;
      apply_next = cmd_valid_i && ok;
      status_next = ok ? NSF_SC_OK : NSF_SC_BAD_FIELD;
      // attributes come only from dword 11
      val_next = cdw11_i;
      if (!cmd_valid_i) begin
         status_next = status_reg;
         sel_next = sel_reg;
         val_next = val_reg;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         done_reg <= 1'b0;
         apply_reg <= 1'b0;
         status_reg <= NSF_SC_OK;
         sel_reg <= 8'h00;
         val_reg <= 32'h0000_0000;
      end else begin
         done_reg <= done_next;
         apply_reg <= apply_next;
         status_reg <= status_next;
         sel_reg <= sel_next;
         val_reg <= val_next;
      end
   end

   assign done_o = done_reg;
   assign status_o = status_reg;
   assign apply_o = apply_reg;
   assign sel_o = sel_reg;
   assign val_o = val_reg;
endmodule // nsf_feat_dec

// *** core/nsf_fmt_table.sv ***
// Purpose: Sixteen-entry format descriptor store with two read ports
// Assumes: Writes come from the register slave on the same clock
// Notes: A refused write leaves the entry unchanged

`timescale 1ns/1ns

module nsf_fmt_table
   import nsf_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wr_en_i,
   input wire logic [3:0] wr_idx_i,
   input wire logic [31:0] wr_data_i,
   output logic wr_bad_o,
   input wire logic [3:0] rd_a_idx_i,
   output logic [31:0] rd_a_o,
   input wire logic [3:0] rd_b_idx_i,
   output logic [31:0] rd_b_o
);
   logic [31:0] desc_reg [16];
   logic [31:0] desc_next [16];
   logic [7:0] wr_exp;

   always_comb begin
      wr_exp = wr_data_i[NSF_DESC_EXP_LSB +: 8];
      wr_bad_o = (wr_exp != 8'h00) && (wr_exp < NSF_MIN_EXP);
      desc_next = desc_reg;
      if (wr_en_i && !wr_bad_o) begin
         // reserved top bits dropped, speed, exponent and count kept
         desc_next[wr_idx_i] = wr_data_i & NSF_DESC_MASK;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         // descriptor zero resets to a valid format, the others to zero
         for (int i = 0; i < 16; i++) begin
            desc_reg[i] <= (i == 0) ? NSF_DESC0_RESET : 32'h0000_0000;
         end
      end else begin
         desc_reg <= desc_next;
      end
   end

   assign rd_a_o = desc_reg[rd_a_idx_i];
   assign rd_b_o = desc_reg[rd_b_idx_i];
endmodule // nsf_fmt_table

// *** core/nsf_pkg.sv ***
// Purpose: Shared constants for the namespace report and feature-setting block
// Assumes: 32-bit classic Wishbone register bus, little-endian report words
// Notes: Report word n holds report bytes 4n..4n+3, lowest byte in bits 7:0
//
// Functional notes
// - Byte 28 reports protection capability: bit4 trailing, bit3 leading, bits2:0 types.
// - Byte 29 reports protection setting; bit3 one means leading eight metadata bytes.
// - Setting type code: 000 off, 001/010/011 types one to three, rest reserved.
// - Sixteen four-byte format descriptors sit at bytes 128..191; descriptor zero mandatory.
// - Bytes 192..383 read reserved zero; bytes 384..4095 are an implementer area.
// - Descriptor bits 25:24 hold speed code 00 best to 11 degraded; 31:26 reserved.
// - Descriptor bits 23:16 hold size exponent; below 9 refused, zero means unused.
// - Descriptor bits 15:0 hold metadata byte count per block.
// - With protection on, leading or trailing eight metadata bytes carry protection data.
// - Identify completion is posted only after the whole structure was written out.
// - Feature-setting uses only first data pointer and command dwords 10 and 11.
// - Dword 10 bits 7:0 select the feature; bits 31:8 reserved and ignored.
// - Format select byte: bit4 appended metadata, bits 3:0 active descriptor index.
// - Descriptors packed from index zero; count reported zero-based, at most sixteen.

package nsf_pkg;
   // Register byte offsets
   localparam logic [7:0] NSF_REG_CAP = 8'h00;
   localparam logic [7:0] NSF_REG_SET = 8'h04;
   localparam logic [7:0] NSF_REG_FSEL = 8'h08;
   localparam logic [7:0] NSF_REG_FCNT = 8'h0c;
   localparam logic [7:0] NSF_REG_STAT = 8'h10;
   localparam logic [7:0] NSF_REG_FIDX = 8'h14;
   localparam logic [7:0] NSF_REG_FVAL = 8'h18;
   localparam logic [7:0] NSF_REG_DESC = 8'h40;
   localparam logic [7:0] NSF_REG_DESC_END = 8'h7c;

   // Field masks and reset values
   localparam logic [7:0] NSF_CAP_MASK = 8'h1f;
   localparam logic [7:0] NSF_SET_MASK = 8'h0f;
   localparam logic [7:0] NSF_FSEL_MASK = 8'h1f;
   localparam logic [31:0] NSF_DESC_MASK = 32'h03ff_ffff;
   localparam logic [31:0] NSF_DESC0_RESET = 32'h0009_0000;
   localparam int NSF_SET_LEAD_BIT = 3;
   localparam int NSF_FSEL_EXT_BIT = 4;
   localparam int NSF_DESC_EXP_LSB = 16;
   localparam logic [7:0] NSF_MIN_EXP = 8'h09;
   localparam logic [15:0] NSF_PI_BYTES = 16'h0008;

   // Protection type codes
   localparam logic [2:0] NSF_PROT_OFF = 3'h0;
   localparam logic [2:0] NSF_PROT_TYPE3 = 3'h3;

   // Report word layout
   localparam logic [9:0] NSF_WORD_FMTINFO = 10'h006;
   localparam logic [9:0] NSF_WORD_PROT = 10'h007;
   localparam logic [9:0] NSF_WORD_DESC0 = 10'h020;
   localparam logic [9:0] NSF_WORD_DESC15 = 10'h02f;
   localparam logic [9:0] NSF_WORD_LAST = 10'h3ff;

   // Feature selectors and completion status
   localparam logic [7:0] NSF_FEAT_FIRST = 8'h01;
   localparam logic [7:0] NSF_FEAT_LAST = 8'h0b;
   localparam logic [7:0] NSF_FEAT_CACHE = 8'h06;
   localparam logic [7:0] NSF_SC_OK = 8'h00;
   localparam logic [7:0] NSF_SC_BAD_FIELD = 8'h02;

   typedef enum logic [1:0] {
      NSF_ID_IDLE,
      NSF_ID_XFER,
      NSF_ID_POST
   } nsf_id_state_e;
endpackage

// *** core/nsf_top.sv ***
// Purpose: Namespace report writer, format and protection settings, feature store
// Assumes: Classic Wishbone slave; identify and feature commands come from queue logic
// Notes: Report words leave through a valid/ready write port toward host memory

`timescale 1ns/1ns

module nsf_top
   import nsf_pkg::*;
#(
   parameter bit CACHE_SUPPORTED = 1'b1,
   parameter logic [7:0] CAP_RESET = 8'h00
) (
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Identify request and report write port
   input wire logic id_start_i,
   input wire logic [63:0] id_buf_addr_i,
   output logic wr_valid_o,
   output logic [63:0] wr_addr_o,
   output logic [31:0] wr_data_o,
   input wire logic wr_ready_i,
   output logic id_cpl_o,
   // Feature-setting command
   input wire logic sf_valid_i,
   input wire logic [31:0] sf_cdw10_i,
   input wire logic [31:0] sf_cdw11_i,
   output logic sf_done_o,
   output logic [7:0] sf_status_o,
   // Active format and protection view
   output logic [7:0] blk_exp_o,
   output logic [15:0] meta_count_o,
   output logic meta_ext_o,
   output logic pi_en_o,
   output logic [2:0] pi_type_o,
   output logic [15:0] pi_offset_o
);
   ////////////////////////////////////////////////////////////////////////////
   // Helpers

   function automatic logic [31:0] merge_lanes(input logic [31:0] old_val,
                                               input logic [31:0] new_val,
                                               input logic [3:0] sel);
      logic [31:0] res;
      res = old_val;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            res[i*8 +: 8] = new_val[i*8 +: 8];
         end
      end
      return res;
   endfunction

   function automatic logic [31:0] report_word(input logic [9:0] idx,
                                               input logic [7:0] cap,
                                               input logic [7:0] set,
                                               input logic [7:0] fsel,
                                               input logic [7:0] fcnt,
                                               input logic [31:0] desc);
      logic [31:0] res;
      res = 32'h0000_0000;
      if (idx == NSF_WORD_FMTINFO) begin
         // zero-based count in byte 25, select in byte 26
         res = {8'h00, fsel, fcnt, 8'h00};
      end else if (idx == NSF_WORD_PROT) begin
         // capability byte 28, setting byte 29
         res = {16'h0000, set, cap};
      end else if (idx >= NSF_WORD_DESC0 && idx <= NSF_WORD_DESC15) begin
         // slots above the count read as unused
         if ({4'h0, idx[3:0]} <= fcnt) begin
            res = desc;
         end
      end
      // reserved and implementer bytes read zero
      return res;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Register slave

   logic ack_reg, ack_next;
   logic [31:0] rdat_reg, rdat_next;
   logic [7:0] cap_reg, cap_next, set_reg, set_next;
   logic [7:0] fsel_reg, fsel_next, fcnt_reg, fcnt_next;
   logic [3:0] fidx_reg, fidx_next;
   logic bad_reg, bad_next;
   logic wb_go, wb_wr, desc_hit, desc_wr, desc_bad;
   logic [31:0] wval, desc_a, desc_b, feat_rd;
   logic [2:0] new_type;
   nsf_id_state_e id_state_reg, id_state_next;

   assign wb_go = wb_cyc_i && wb_stb_i && !ack_reg;
   assign wb_wr = wb_go && wb_we_i;
   assign desc_hit = (wb_adr_i >= NSF_REG_DESC) && (wb_adr_i <= NSF_REG_DESC_END);
   assign desc_wr = wb_wr && desc_hit;

   always_comb begin
      ack_next = wb_go;
      rdat_next = 32'h0000_0000;
      cap_next = cap_reg;
      set_next = set_reg;
      fsel_next = fsel_reg;
      fcnt_next = fcnt_reg;
      fidx_next = fidx_reg;
      bad_next = bad_reg;
      wval = 32'h0000_0000;
      new_type = 3'h0;
      if (wb_wr) begin
         bad_next = 1'b0;
         if (wb_adr_i == NSF_REG_CAP) begin
            wval = merge_lanes({24'h0, cap_reg}, wb_dat_i, wb_sel_i);
            // reserved capability bits forced to zero
            cap_next = wval[7:0] & NSF_CAP_MASK;
         end else if (wb_adr_i == NSF_REG_SET) begin
            wval = merge_lanes({24'h0, set_reg}, wb_dat_i, wb_sel_i);
            new_type = wval[2:0];
            if (new_type > NSF_PROT_TYPE3) begin
               bad_next = 1'b1;
            end else begin
               // placement bit and type kept, bits 7:4 zero
               set_next = wval[7:0] & NSF_SET_MASK;
            end
         end else if (wb_adr_i == NSF_REG_FSEL) begin
            wval = merge_lanes({24'h0, fsel_reg}, wb_dat_i, wb_sel_i);
            // index must name a reported descriptor
            if ({4'h0, wval[3:0]} > fcnt_reg) begin
               bad_next = 1'b1;
            end else begin
               fsel_next = wval[7:0] & NSF_FSEL_MASK;
            end
         end else if (wb_adr_i == NSF_REG_FCNT) begin
            wval = merge_lanes({24'h0, fcnt_reg}, wb_dat_i, wb_sel_i);
            // four-bit zero-based count caps at sixteen
            fcnt_next = {4'h0, wval[3:0]};
         end else if (wb_adr_i == NSF_REG_FIDX) begin
            wval = merge_lanes({28'h0, fidx_reg}, wb_dat_i, wb_sel_i);
            fidx_next = wval[3:0];
         end else if (desc_hit) begin
            bad_next = desc_bad;
         end
      end
      if (wb_go && !wb_we_i) begin
         if (wb_adr_i == NSF_REG_CAP) begin
            rdat_next = {24'h0, cap_reg};
         end else if (wb_adr_i == NSF_REG_SET) begin
            rdat_next = {24'h0, set_reg};
         end else if (wb_adr_i == NSF_REG_FSEL) begin
            rdat_next = {24'h0, fsel_reg};
         end else if (wb_adr_i == NSF_REG_FCNT) begin
            rdat_next = {24'h0, fcnt_reg};
         end else if (wb_adr_i == NSF_REG_STAT) begin
            rdat_next = {7'h0, sf_done_o, sf_status_o, 14'h0, bad_reg,
                         (id_state_reg != NSF_ID_IDLE)};
         end else if (wb_adr_i == NSF_REG_FIDX) begin
            rdat_next = {28'h0, fidx_reg};
         end else if (wb_adr_i == NSF_REG_FVAL) begin
            rdat_next = feat_rd;
         end else if (desc_hit) begin
            rdat_next = desc_b;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_reg <= 1'b0;
         rdat_reg <= 32'h0000_0000;
         cap_reg <= CAP_RESET & NSF_CAP_MASK;
         set_reg <= 8'h00;
         fsel_reg <= 8'h00;
         fcnt_reg <= 8'h00;
         fidx_reg <= 4'h0;
         bad_reg <= 1'b0;
      end else begin
         ack_reg <= ack_next;
         rdat_reg <= rdat_next;
         cap_reg <= cap_next;
         set_reg <= set_next;
         fsel_reg <= fsel_next;
         fcnt_reg <= fcnt_next;
         fidx_reg <= fidx_next;
         bad_reg <= bad_next;
      end
   end

   assign wb_ack_o = ack_reg;
   assign wb_dat_o = rdat_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Format descriptors

   logic [9:0] widx_reg, widx_next;
   logic [3:0] rd_b_idx;

   // Descriptor port b serves the bus during a descriptor access, the active format otherwise
   assign rd_b_idx = (wb_go && desc_hit) ? wb_adr_i[5:2] : fsel_reg[3:0];

   nsf_fmt_table u_fmt (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .wr_en_i(desc_wr),
      .wr_idx_i(wb_adr_i[5:2]),
      .wr_data_i(merge_lanes(desc_b, wb_dat_i, wb_sel_i)),
      .wr_bad_o(desc_bad),
      .rd_a_idx_i(widx_next[3:0]),
      .rd_a_o(desc_a),
      .rd_b_idx_i(rd_b_idx),
      .rd_b_o(desc_b)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Active format and protection view

   logic [7:0] exp_reg, exp_next;
   logic [15:0] meta_reg, meta_next, pio_reg, pio_next;
   logic ext_reg, ext_next, pien_reg, pien_next;
   logic [2:0] pit_reg, pit_next;

   always_comb begin
      exp_reg_hold: begin
         exp_next = exp_reg;
         meta_next = meta_reg;
      end
      // Only sample the table when the bus is not borrowing port b
      if (!(wb_go && desc_hit)) begin
         exp_next = desc_b[NSF_DESC_EXP_LSB +: 8];
         meta_next = desc_b[15:0];
      end
      ext_next = fsel_reg[NSF_FSEL_EXT_BIT];
      pit_next = set_reg[2:0];
      pien_next = (set_reg[2:0] != NSF_PROT_OFF);
      // protection bytes at the front or the back of the metadata
      if (set_reg[NSF_SET_LEAD_BIT] || meta_reg < NSF_PI_BYTES) begin
         pio_next = 16'h0000;
      end else begin
         pio_next = meta_reg - NSF_PI_BYTES;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         exp_reg <= 8'h00;
         meta_reg <= 16'h0000;
         ext_reg <= 1'b0;
         pien_reg <= 1'b0;
         pit_reg <= 3'h0;
         pio_reg <= 16'h0000;
      end else begin
         exp_reg <= exp_next;
         meta_reg <= meta_next;
         ext_reg <= ext_next;
         pien_reg <= pien_next;
         pit_reg <= pit_next;
         pio_reg <= pio_next;
      end
   end

   assign blk_exp_o = exp_reg;
   assign meta_count_o = meta_reg;
   assign meta_ext_o = ext_reg;
   assign pi_en_o = pien_reg;
   assign pi_type_o = pit_reg;
   assign pi_offset_o = pio_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Identify report writer

   logic wv_reg, wv_next, cpl_reg, cpl_next;
   logic [63:0] wa_reg, wa_next;
   logic [31:0] wd_reg, wd_next;

   always_comb begin
      id_state_next = id_state_reg;
      widx_next = widx_reg;
      wv_next = wv_reg;
      wa_next = wa_reg;
      wd_next = wd_reg;
      cpl_next = 1'b0;
      case (id_state_reg)
         NSF_ID_IDLE: begin
            if (id_start_i) begin
               widx_next = 10'h000;
               wv_next = 1'b1;
               wa_next = id_buf_addr_i;
               wd_next = report_word(10'h000, cap_reg, set_reg, fsel_reg, fcnt_reg, desc_a);
               id_state_next = NSF_ID_XFER;
            end
         end
         NSF_ID_XFER: begin
            if (wr_ready_i) begin
               if (widx_reg == NSF_WORD_LAST) begin
                  wv_next = 1'b0;
                  id_state_next = NSF_ID_POST;
               end else begin
                  widx_next = widx_reg + 10'h001;
                  wa_next = wa_reg + 64'h0000_0000_0000_0004;
                  wd_next = report_word(widx_next, cap_reg, set_reg, fsel_reg, fcnt_reg,
                                        desc_a);
               end
            end
         end
         NSF_ID_POST: begin
            // completion only after the last word was taken
            cpl_next = 1'b1;
            id_state_next = NSF_ID_IDLE;
         end
         default: begin
            id_state_next = NSF_ID_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         id_state_reg <= NSF_ID_IDLE;
         widx_reg <= 10'h000;
         wv_reg <= 1'b0;
         wa_reg <= 64'h0000_0000_0000_0000;
         wd_reg <= 32'h0000_0000;
         cpl_reg <= 1'b0;
      end else begin
         id_state_reg <= id_state_next;
         widx_reg <= widx_next;
         wv_reg <= wv_next;
         wa_reg <= wa_next;
         wd_reg <= wd_next;
         cpl_reg <= cpl_next;
      end
   end

   assign wr_valid_o = wv_reg;
   assign wr_addr_o = wa_reg;
   assign wr_data_o = wd_reg;
   assign id_cpl_o = cpl_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Feature-setting commands and feature store

   logic dec_apply;
   logic [7:0] dec_sel;
   logic [31:0] dec_val;
   logic [31:0] feat_reg [16];
   logic [31:0] feat_next [16];

   nsf_feat_dec #(
      .CACHE_SUPPORTED(CACHE_SUPPORTED)
   ) u_dec (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .cmd_valid_i(sf_valid_i),
      .cdw10_i(sf_cdw10_i),
      .cdw11_i(sf_cdw11_i),
      .done_o(sf_done_o),
      .status_o(sf_status_o),
      .apply_o(dec_apply),
      .sel_o(dec_sel),
      .val_o(dec_val)
   );

   always_comb begin
      feat_next = feat_reg;
      // attributes land on the selected feature only; failures never apply
      if (dec_apply) begin
         feat_next[dec_sel[3:0]] = dec_val;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int i = 0; i < 16; i++) begin
            feat_reg[i] <= 32'h0000_0000;
         end
      end else begin
         feat_reg <= feat_next;
      end
   end

   assign feat_rd = feat_reg[fidx_reg];
endmodule // nsf_top

// *** dv/nsf_host_mem.sv ***
// Purpose: Host memory taking report words
// Assumes: Base address held for a whole report
// Notes: Refuses every third cycle so the sender must hold
`timescale 1ns/1ns
module nsf_host_mem (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wr_valid_i,
   input wire logic [63:0] wr_addr_i,
   input wire logic [31:0] wr_data_i,
   input wire logic [63:0] base_i,
   output logic wr_ready_o
);
   logic [31:0] mem [0:1023];
   logic [1:0] cnt_reg;
   logic [63:0] off;
   assign off = wr_addr_i - base_i;
   assign wr_ready_o = cnt_reg != 2'h2;
   always_ff @(posedge clk_i) begin
      cnt_reg <= (rst_i || cnt_reg == 2'h2) ? 2'h0 : cnt_reg + 2'h1;
      if (wr_valid_i && wr_ready_o) begin
         mem[off[11:2]] <= wr_data_i;
      end
   end
endmodule // nsf_host_mem

// *** dv/nsf_top_properties.sv ***
// Purpose: Port checks for nsf_top
// Assumes: Report base address stays fixed during a report
// Notes: Bound from the bench top file
`timescale 1ns/1ns
module nsf_top_props (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic [63:0] id_buf_addr_i,
   input wire logic wr_valid_o,
   input wire logic [63:0] wr_addr_o,
   input wire logic [31:0] wr_data_o,
   input wire logic wr_ready_i,
   input wire logic id_cpl_o,
   input wire logic sf_valid_i,
   input wire logic [31:0] sf_cdw10_i,
   input wire logic sf_done_o,
   input wire logic [7:0] sf_status_o
);
   logic [63:0] off;
   logic [7:0] fsel;
   assign off = wr_addr_o - id_buf_addr_i;
   assign fsel = sf_cdw10_i[7:0];
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("bus ack late");
   a_sf_bad: assert property (
      sf_valid_i && (fsel == 8'h00 || fsel > 8'h0b) |=> sf_done_o && sf_status_o == 8'h02)
      else $error("bad selector accepted");
   a_sf_good: assert property (
      sf_valid_i && fsel != 8'h00 && fsel <= 8'h0b |=> sf_done_o && sf_status_o == 8'h00)
      else $error("good selector refused");
   a_cpl_after: assert property ($fell(wr_valid_o) |-> ##1 id_cpl_o)
      else $error("completion missing");
   a_cpl_alone: assert property (id_cpl_o |-> !wr_valid_o && $past(wr_valid_o, 2))
      else $error("completion early");
   a_wr_hold: assert property (wr_valid_o && !wr_ready_i |=> wr_valid_o && $stable(wr_addr_o)
      && $stable(wr_data_o))
      else $error("word not held");
   a_addr_step: assert property (
      wr_valid_o && wr_ready_i ##1 wr_valid_o |-> wr_addr_o == $past(wr_addr_o) + 64'h4)
      else $error("address step wrong");
   a_resv_zero: assert property (wr_valid_o && off >= 64'hc0 |-> wr_data_o == 32'h0)
      else $error("reserved area not zero");
   a_desc_resv: assert property (
      wr_valid_o && off >= 64'h80 && off < 64'hc0 |-> wr_data_o[31:26] == 6'h0)
      else $error("descriptor reserved bits set");
   a_prot_resv: assert property (
      wr_valid_o && off == 64'h1c |-> wr_data_o[31:16] == 16'h0 && wr_data_o[7:5] == 3'h0
      && wr_data_o[15:12] == 4'h0)
      else $error("protection reserved bits set");
endmodule // nsf_top_props

// *** dv/nsf_top_test.sv ***
// Purpose: Self-checking bench for nsf_top
// Assumes: Optional cache selector supported
// Notes: Report words land in the host memory model
`timescale 1ns/1ns
module nsf_top_test;
   import nsf_pkg::*;
   localparam logic [7:0] CAP_VAL = 8'h15;
   logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, id_start_i, wr_valid_o;
   logic wr_ready_i, id_cpl_o, sf_valid_i, sf_done_o, meta_ext_o, pi_en_o;
   logic [7:0] wb_adr_i, sf_status_o, blk_exp_o;
   logic [3:0] wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o, wr_data_o, sf_cdw10_i, sf_cdw11_i, rdat, exp_w;
   logic [63:0] id_buf_addr_i, wr_addr_o;
   logic [15:0] meta_count_o, pi_offset_o;
   logic [2:0] pi_type_o;
   int errors = 0;
   int n_compared = 0;
   int cycles = 0;
   nsf_top #(.CAP_RESET(CAP_VAL)) u_dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
      .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .id_start_i, .id_buf_addr_i,
      .wr_valid_o, .wr_addr_o, .wr_data_o, .wr_ready_i, .id_cpl_o, .sf_valid_i, .sf_cdw10_i,
      .sf_cdw11_i, .sf_done_o, .sf_status_o, .blk_exp_o, .meta_count_o, .meta_ext_o,
      .pi_en_o, .pi_type_o, .pi_offset_o);
   nsf_host_mem u_host (.clk_i, .rst_i, .wr_valid_i(wr_valid_o), .wr_addr_i(wr_addr_o),
      .wr_data_i(wr_data_o), .base_i(id_buf_addr_i), .wr_ready_o(wr_ready_i));
   task automatic final_report;
      if (errors == 0 && n_compared > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do begin
         @(posedge clk_i);
      end while (!wb_ack_o);
      rdat = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      wb(1'b0, a, 32'h0);
      chk(rdat, exp);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         final_report;
      end
   end
   initial begin
      {wb_cyc_i, wb_stb_i, wb_we_i, id_start_i, sf_valid_i} = 5'h0;
      {wb_adr_i, wb_dat_i, sf_cdw10_i, sf_cdw11_i} = 104'h0;
      wb_sel_i = 4'hf;
      id_buf_addr_i = 64'h0000_0001_0000_2000;
      rst_i = 1'b1;
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(NSF_REG_CAP, {24'h0, CAP_VAL});
      rd(NSF_REG_DESC, 32'h0009_0000);
      rd(8'h30, 32'h0);
      for (int c = 0; c < 8; c++) begin
         wb(1'b1, NSF_REG_SET, {28'h0, 1'b1, c[2:0]});
         rd(NSF_REG_SET, {28'h0, 1'b1, c < 4 ? c[2:0] : 3'h3});
      end
      rd(NSF_REG_STAT, 32'h2);
      wb(1'b1, NSF_REG_DESC + 8'h4, 32'hfd0c_0010);
      rd(NSF_REG_DESC + 8'h4, 32'h010c_0010);
      wb(1'b1, NSF_REG_DESC + 8'h4, 32'h0008_0010);
      rd(NSF_REG_DESC + 8'h4, 32'h010c_0010);
      wb(1'b1, NSF_REG_FCNT, 32'h1);
      wb(1'b1, NSF_REG_FSEL, 32'h12);
      rd(NSF_REG_FSEL, 32'h0);
      wb(1'b1, NSF_REG_FSEL, 32'h11);
      repeat (3) @(posedge clk_i);
      chk({blk_exp_o, meta_count_o, meta_ext_o, pi_en_o, pi_type_o, pi_offset_o},
         {8'h0c, 16'h0010, 2'h3, 3'h3, 16'h0});
      wb(1'b1, NSF_REG_SET, 32'h3);
      repeat (3) @(posedge clk_i);
      chk({pi_en_o, pi_offset_o}, {1'b1, 16'h0008});
      @(posedge clk_i);
      id_start_i <= 1'b1;
      @(posedge clk_i);
      id_start_i <= 1'b0;
      while (!id_cpl_o) @(posedge clk_i);
      for (int i = 0; i < 1024; i++) begin
         exp_w = (i == 6) ? 32'h0011_0100 : (i == 7) ? {16'h0003, CAP_VAL} : 32'h0;
         exp_w = (i == 32) ? 32'h0009_0000 : (i == 33) ? 32'h010c_0010 : exp_w;
         chk(u_host.mem[i], exp_w);
      end
      for (int s = 0; s < 14; s++) begin
         @(posedge clk_i);
         sf_valid_i <= 1'b1;
         sf_cdw10_i <= {24'hffffff, s[7:0]};
         sf_cdw11_i <= 32'h5a00_0000 + s;
         @(posedge clk_i);
         sf_valid_i <= 1'b0;
         @(posedge clk_i);
         chk({sf_done_o, sf_status_o}, {1'b1, (s == 0 || s > 11) ? 8'h02 : 8'h00});
      end
      rd(NSF_REG_STAT, 32'h0002_0000);
      for (int s = 0; s < 14; s++) begin
         wb(1'b1, NSF_REG_FIDX, 32'(s));
         rd(NSF_REG_FVAL, (s == 0 || s > 11) ? 32'h0 : 32'h5a00_0000 + s);
      end
      final_report;
   end
endmodule // nsf_top_test
bind nsf_top nsf_top_props u_props (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
   .id_buf_addr_i, .wr_valid_o, .wr_addr_o, .wr_data_o, .wr_ready_i, .id_cpl_o, .sf_valid_i,
   .sf_cdw10_i, .sf_done_o, .sf_status_o);
